// >>> pkg/rst_seq_pkg.sv
package rst_seq_pkg;

	// Timing of the start-up sequence.
	localparam int OST_CYCLES = 1024;
	localparam int POWERUP_TIMER_PERIODS = 2048;
	localparam int CLOCK_FREQ_MHZ = 20;
	localparam int PLL_LOCK_TIME_US = 2000;
	localparam int PLL_LOCK_CYCLES = PLL_LOCK_TIME_US * CLOCK_FREQ_MHZ;

	// Program counter values.
	localparam int PC_WIDTH = 21;
	localparam logic [20:0] RESET_VECTOR = 21'h00000;
	localparam logic [20:0] HIGH_INT_VECTOR = 21'h00008;
	localparam logic [20:0] LOW_INT_VECTOR = 21'h00018;
	localparam logic [20:0] PC_STEP = 21'h00002;

	// Brown-out configuration that hands control to software.
	localparam logic [1:0] BROWNOUT_SW_CFG = 2'h1;

	typedef enum logic [3:0] {
		LOW_POWER_CRYSTAL_CFG,
		STD_CRYSTAL_CFG,
		HIGH_SPEED_CRYSTAL_CFG,
		HIGH_SPEED_CRYSTAL_PLL_CFG,
		EXT_CLOCK_CFG,
		EXT_CLOCK_IO_CFG,
		EXT_RC_CFG,
		EXT_RC_IO_CFG,
		INTERNAL_OSC_CFG_A,
		INTERNAL_OSC_CFG_B
	} osc_cfg_t;

	typedef enum logic [1:0] {
		PM_FULL,
		PM_RUN,
		PM_IDLE,
		PM_SLEEP
	} pm_mode_t;

	typedef enum logic [2:0] {
		ST_POR,
		ST_POWERUP_TIMER,
		ST_OST,
		ST_PLL,
		ST_HOLD,
		ST_RUN
	} seq_state_t;

	typedef struct packed {
		logic soft_brownout_enable;
		logic reset_instr_flag;
		logic watchdog_timeout_flag;
		logic power_down_flag;
		logic power_on_flag;
		logic brown_out_flag;
		logic stack_full_flag;
		logic stack_underflow_flag;
	} flags_t;

	// Values after a power-on reset.
	localparam flags_t FLAGS_POR = '{
		soft_brownout_enable: 1'b1,
		reset_instr_flag: 1'b1,
		watchdog_timeout_flag: 1'b1,
		power_down_flag: 1'b1,
		power_on_flag: 1'b0,
		brown_out_flag: 1'b0,
		stack_full_flag: 1'b0,
		stack_underflow_flag: 1'b0
	};

endpackage

// >>> pkg/timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
	logic start;
	logic tick;
	logic done;
	modport ctl(output start, output tick, input done);
	modport tmr(input start, input tick, output done);
endinterface
`default_nettype wire

// >>> hdl/delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module delay_timer #(
	parameter int COUNT = 1024
) (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Control side.
	timer_if.tmr tmr
);
	localparam int W = $clog2(COUNT + 1);
	localparam logic [W-1:0] LAST = W'(COUNT - 1);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic run_q;
	logic run_d;
	logic done_q;
	logic done_d;
	wire logic last_tick;

	assign last_tick = run_q && tmr.tick && (cnt_q == LAST);
	assign tmr.done = done_q;

	// A start while running reloads, so an aborted sequence never leaks
	// a stale expiry into the next one.
	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		done_d = 1'b0;
		if (tmr.start) begin
			cnt_d = '0;
			run_d = 1'b1;
		end else if (last_tick) begin
			run_d = 1'b0;
			done_d = 1'b1;
		end else if (run_q && tmr.tick) begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			done_q <= done_d;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/reset_cause_flags.sv
`timescale 1ns/1ps
`default_nettype none
module reset_cause_flags (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Context.
	input wire rst_seq_pkg::pm_mode_t pm_mode_in,
	input wire logic [1:0] brownout_enable_cfg_in,
	// Qualified events, one-cycle pulses.
	input wire logic reset_instr_ev_in,
	input wire logic brown_out_ev_in,
	input wire logic master_clear_pin_ev_in,
	input wire logic wdt_ev_in,
	input wire logic stack_full_ev_in,
	input wire logic stack_underflow_ev_in,
	input wire logic int_wake_ev_in,
	// Software write.
	input wire logic flag_write_in,
	input wire rst_seq_pkg::flags_t flag_data_in,
	// Flags.
	output rst_seq_pkg::flags_t flags_out
);
	import rst_seq_pkg::*;

	flags_t flags_q;
	flags_t flags_d;
	wire logic low_pm;

	assign low_pm = (pm_mode_in == PM_IDLE) || (pm_mode_in == PM_SLEEP);
	assign flags_out = flags_q;

	// Hardware events are applied after the software write so that an
	// event landing in the same cycle as a clear is never lost.
	always_comb begin
		flags_d = flags_q;
		if (flag_write_in) begin
			flags_d = flag_data_in;
		end
		if (reset_instr_ev_in) begin
			flags_d.reset_instr_flag = 1'b0;
		end
		if (brown_out_ev_in) begin
			flags_d.reset_instr_flag = 1'b1;
			flags_d.watchdog_timeout_flag = 1'b1;
			flags_d.power_down_flag = 1'b1;
			flags_d.brown_out_flag = 1'b0;
		end
		if (master_clear_pin_ev_in) begin
			case (pm_mode_in)
				PM_RUN: begin
					flags_d.watchdog_timeout_flag = 1'b1;
				end
				PM_IDLE, PM_SLEEP: begin
					flags_d.watchdog_timeout_flag = 1'b1;
					flags_d.power_down_flag = 1'b0;
				end
				default: begin
					flags_d = flags_d;
				end
			endcase
		end
		if (wdt_ev_in) begin
			flags_d.watchdog_timeout_flag = 1'b0;
			if (low_pm) begin
				flags_d.power_down_flag = 1'b0;
			end
		end
		if (stack_full_ev_in) begin
			flags_d.stack_full_flag = 1'b1;
		end
		if (stack_underflow_ev_in) begin
			flags_d.stack_underflow_flag = 1'b1;
		end
		if (int_wake_ev_in) begin
			flags_d.power_down_flag = 1'b0;
		end
		if (brownout_enable_cfg_in != BROWNOUT_SW_CFG) begin
			flags_d.soft_brownout_enable = 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flags_q <= FLAGS_POR;
		end else begin
			flags_q <= flags_d;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/reset_timeout_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Oscillator start-up holds reset 1024 oscillator cycles, after the power-up timer.
// - Start-up count only in the four crystal configurations.
// - Start-up count also on exit from power managed modes, without power-up timer.
// - With PLL configuration, a fixed 2 ms lock delay follows the start-up count.
// - Wait for power-on pulse to clear, then power-up timer, then start-up count.
// - Power-up timer adds its delay when its disable setting is 0.
// - Non-crystal configuration with power-up timer disabled releases without delay.
// - Time-outs run regardless of master clear; releasing it later starts at once.
// - Undefined registers keep contents; defined ones take a reset-type value.
// - Watchdog wake-up resumes operation and leaves registers unchanged.
// - Power-on sets PC 0, RI TO PD to 1, others to 0.
// - Reset instruction clears RI; brown-out sets RI TO PD and clears BOR flag.
// - Master clear in run modes sets TO, restarts at address 0.
// - Master clear in idle or sleep sets TO and clears PD.
// - Master clear in full power restarts at 0, all flags unchanged.
// - Watchdog time-out in full or run mode resets to 0, clears TO.
// - Watchdog in idle or sleep wakes at PC plus 2, clears TO and PD.
// - Interrupt wake continues at PC plus 2 or vector, clears PD.
// - With stack reset enabled, full or underflow resets and sets its flag.
// - With stack reset disabled, underflow only sets its flag.
// - Software brown-out enable is 1 after power-on, masked unless config is 01.
// - Power-up timer counts 2048 internal RC periods, holding reset.
module reset_timeout_sequencer #(
	parameter int PLL_LOCK_CYCLES = rst_seq_pkg::PLL_LOCK_CYCLES
) (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Supply monitors.
	input wire logic por_pulse_in,
	input wire logic brown_out_in,
	// Pins.
	input wire logic master_clear_pin_n_in,
	input wire logic osc_input_pin_in,
	input wire logic internal_rc_clock_in,
	// Configuration.
	input wire rst_seq_pkg::osc_cfg_t osc_cfg_in,
	input wire logic powerup_timer_disable_cfg_in,
	input wire logic stack_reset_enable_cfg_in,
	input wire logic [1:0] brownout_enable_cfg_in,
	// Core events.
	input wire rst_seq_pkg::pm_mode_t pm_mode_in,
	input wire logic reset_instr_in,
	input wire logic watchdog_timeout_in,
	input wire logic stack_full_in,
	input wire logic stack_underflow_in,
	input wire logic interrupt_wake_in,
	input wire logic global_int_enable_high_in,
	input wire logic global_int_enable_low_in,
	input wire logic int_high_priority_in,
	input wire logic [rst_seq_pkg::PC_WIDTH-1:0] pc_in,
	// Software access to the status flags.
	input wire logic flag_write_in,
	input wire rst_seq_pkg::flags_t flag_data_in,
	// Outputs.
	output logic core_reset_out,
	output logic clock_wait_out,
	output logic pc_load_out,
	output logic [rst_seq_pkg::PC_WIDTH-1:0] pc_value_out,
	output rst_seq_pkg::flags_t status_flags_out
);
	import rst_seq_pkg::*;

	timer_if powerup_timer_if();
	timer_if ost_if();
	timer_if pll_if();

	seq_state_t state_q;
	seq_state_t state_d;
	logic wake_q;
	logic wake_d;
	logic rc_q;
	logic osc_q;
	logic master_clear_pin_prev_q;
	logic bo_prev_q;
	logic pc_load_q;
	logic pc_load_d;
	logic [PC_WIDTH-1:0] pc_q;
	logic [PC_WIDTH-1:0] pc_d;
	logic powerup_timer_start;
	logic ost_start;
	logic pll_start;

	wire logic crystal;
	wire logic pll_mode;
	wire logic low_pm;
	wire logic in_run;
	wire logic master_clear_pin_ev;
	wire logic bo_ev;
	wire logic wdt_reset;
	wire logic wdt_wake;
	wire logic int_wake;
	wire logic instr_reset;
	wire logic stk_full_ev;
	wire logic stk_unf_ev;
	wire logic stk_reset;
	wire logic soft_reset;
	wire logic wake_ev;
	wire logic [PC_WIDTH-1:0] pc_next_instr;
	wire logic [PC_WIDTH-1:0] int_target;

	assign crystal = (osc_cfg_in == LOW_POWER_CRYSTAL_CFG)
		|| (osc_cfg_in == STD_CRYSTAL_CFG)
		|| (osc_cfg_in == HIGH_SPEED_CRYSTAL_CFG)
		|| (osc_cfg_in == HIGH_SPEED_CRYSTAL_PLL_CFG);
	assign pll_mode = (osc_cfg_in == HIGH_SPEED_CRYSTAL_PLL_CFG);
	assign low_pm = (pm_mode_in == PM_IDLE) || (pm_mode_in == PM_SLEEP);
	assign in_run = (state_q == ST_RUN);

	// Inputs are synchronous, so edges are found against one stage.
	assign powerup_timer_if.tick = internal_rc_clock_in && !rc_q;
	assign ost_if.tick = osc_input_pin_in && !osc_q;
	assign pll_if.tick = 1'b1;
	assign powerup_timer_if.start = powerup_timer_start;
	assign ost_if.start = ost_start;
	assign pll_if.start = pll_start;

	assign master_clear_pin_ev = in_run && master_clear_pin_prev_q && !master_clear_pin_n_in;
	assign bo_ev = brown_out_in && !bo_prev_q;
	assign wdt_reset = in_run && watchdog_timeout_in && !low_pm;
	assign wdt_wake = in_run && watchdog_timeout_in && low_pm;
	assign int_wake = in_run && interrupt_wake_in && low_pm;
	assign instr_reset = in_run && reset_instr_in;
	// Stack full is flagged in any setting; only the reset is gated.
	assign stk_full_ev = in_run && stack_full_in;
	assign stk_unf_ev = in_run && stack_underflow_in;
	assign stk_reset = stack_reset_enable_cfg_in
		&& (stk_full_ev || stk_unf_ev);
	assign soft_reset = master_clear_pin_ev || wdt_reset || instr_reset || stk_reset;
	assign wake_ev = wdt_wake || int_wake;
	assign pc_next_instr = pc_in + PC_STEP;
	assign int_target = int_high_priority_in ? HIGH_INT_VECTOR
		: LOW_INT_VECTOR;

	// Reset stays on through the whole timed sequence and while the pin
	// is low; a crystal-configuration wake-up stalls the clock instead of resetting the core.
	assign core_reset_out = (!in_run && !wake_q) || !master_clear_pin_n_in;
	assign clock_wait_out = wake_q;
	assign pc_load_out = pc_load_q;
	assign pc_value_out = pc_q;

	delay_timer #(
		.COUNT(POWERUP_TIMER_PERIODS)
	) u_powerup_timer (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.tmr(powerup_timer_if.tmr)
	);

	delay_timer #(
		.COUNT(OST_CYCLES)
	) u_osc_startup_counter (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.tmr(ost_if.tmr)
	);

	delay_timer #(
		.COUNT(PLL_LOCK_CYCLES)
	) u_pll_lock_delay (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.tmr(pll_if.tmr)
	);

	reset_cause_flags u_flags (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.pm_mode_in(pm_mode_in),
		.brownout_enable_cfg_in(brownout_enable_cfg_in),
		.reset_instr_ev_in(instr_reset),
		.brown_out_ev_in(bo_ev),
		.master_clear_pin_ev_in(master_clear_pin_ev),
		.wdt_ev_in(wdt_reset || wdt_wake),
		.stack_full_ev_in(stk_full_ev),
		.stack_underflow_ev_in(stk_unf_ev),
		.int_wake_ev_in(int_wake),
		.flag_write_in(flag_write_in),
		.flag_data_in(flag_data_in),
		.flags_out(status_flags_out)
	);

	// Sequencer. The timers count from the power-on and brown-out inputs alone, so the
	// pin only gates the final release in ST_HOLD.
	always_comb begin
		state_d = state_q;
		wake_d = wake_q;
		powerup_timer_start = 1'b0;
		ost_start = 1'b0;
		pll_start = 1'b0;
		case (state_q)
			ST_POR: begin
				if (!por_pulse_in && !brown_out_in) begin
					if (!powerup_timer_disable_cfg_in) begin
						powerup_timer_start = 1'b1;
						state_d = ST_POWERUP_TIMER;
					end else if (crystal) begin
						ost_start = 1'b1;
						state_d = ST_OST;
					end else begin
						state_d = ST_HOLD;
					end
				end
			end
			ST_POWERUP_TIMER: begin
				if (powerup_timer_if.done) begin
					if (crystal) begin
						ost_start = 1'b1;
						state_d = ST_OST;
					end else begin
						state_d = ST_HOLD;
					end
				end
			end
			ST_OST: begin
				if (ost_if.done) begin
					if (pll_mode) begin
						pll_start = 1'b1;
						state_d = ST_PLL;
					end else if (wake_q) begin
						wake_d = 1'b0;
						state_d = ST_RUN;
					end else begin
						state_d = ST_HOLD;
					end
				end
			end
			ST_PLL: begin
				if (pll_if.done) begin
					wake_d = 1'b0;
					state_d = wake_q ? ST_RUN : ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (master_clear_pin_n_in) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (soft_reset) begin
					state_d = ST_HOLD;
				end else if (wake_ev && crystal) begin
					wake_d = 1'b1;
					ost_start = 1'b1;
					state_d = ST_OST;
				end
			end
			default: begin
				state_d = ST_POR;
			end
		endcase
		// A supply event restarts the whole power-up sequence.
		if (por_pulse_in || brown_out_in) begin
			state_d = ST_POR;
			wake_d = 1'b0;
		end
	end

	// Program counter outcome. Registers other than these are left to
	// their owners, so a wake-up disturbs nothing else here.
	always_comb begin
		pc_load_d = 1'b0;
		pc_d = pc_q;
		if (soft_reset || bo_ev) begin
			pc_load_d = 1'b1;
			pc_d = RESET_VECTOR;
		end else if (wdt_wake) begin
			pc_load_d = 1'b1;
			pc_d = pc_next_instr;
		end else if (int_wake) begin
			pc_load_d = 1'b1;
			if (global_int_enable_high_in || global_int_enable_low_in) begin
				pc_d = int_target;
			end else begin
				pc_d = pc_next_instr;
			end
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= ST_POR;
			wake_q <= 1'b0;
			rc_q <= 1'b0;
			osc_q <= 1'b0;
			master_clear_pin_prev_q <= 1'b1;
			bo_prev_q <= 1'b0;
			pc_load_q <= 1'b0;
			pc_q <= RESET_VECTOR;
		end else begin
			state_q <= state_d;
			wake_q <= wake_d;
			rc_q <= internal_rc_clock_in;
			osc_q <= osc_input_pin_in;
			master_clear_pin_prev_q <= master_clear_pin_n_in;
			bo_prev_q <= brown_out_in;
			pc_load_q <= pc_load_d;
			pc_q <= pc_d;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/osc_master_clear_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module osc_master_clear_pin_model (
	// Clock.
	input wire logic clock_in,
	// Request from the bench to pull the pin low.
	input wire logic hold_low_in,
	// Far-side lines.
	output logic osc_out,
	output logic rc_out,
	output logic master_clear_pin_n_out
);
	initial begin
		osc_out = 1'h0;
		rc_out = 1'h0;
	end
	// A powered resonator and the RC cell run free, so neither ever stops.
	always @(negedge clock_in) begin
		osc_out <= ~osc_out;
		rc_out <= ~rc_out;
	end
	// The pin has a pull-up, so it is high whenever nobody pulls it down.
	assign master_clear_pin_n_out = ~hold_low_in;
endmodule
`default_nettype wire

// >>> testbench/reset_timeout_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rts_asserts (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic por_pulse_in,
	input wire logic brown_out_in,
	input wire logic master_clear_pin_n_in,
	input wire rst_seq_pkg::osc_cfg_t osc_cfg_in,
	input wire logic powerup_timer_disable_cfg_in,
	input wire logic stack_reset_enable_cfg_in,
	input wire rst_seq_pkg::pm_mode_t pm_mode_in,
	input wire logic reset_instr_in,
	input wire logic watchdog_timeout_in,
	input wire logic stack_full_in,
	input wire logic stack_underflow_in,
	input wire logic interrupt_wake_in,
	input wire logic global_int_enable_high_in,
	input wire logic global_int_enable_low_in,
	input wire logic int_high_priority_in,
	input wire logic [20:0] pc_in,
	input wire logic core_reset_out,
	input wire logic clock_wait_out,
	input wire logic pc_load_out,
	input wire logic [20:0] pc_value_out,
	input wire rst_seq_pkg::flags_t status_flags_out
);
	import rst_seq_pkg::*;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	// Event checks judge only single events seen by a running core.
	wire logic live = !core_reset_out && !clock_wait_out &&
		master_clear_pin_n_in && !por_pulse_in && !brown_out_in;
	wire logic solo = live && !reset_instr_in && !stack_full_in &&
		!stack_underflow_in;
	wire logic nap = pm_mode_in == PM_IDLE || pm_mode_in == PM_SLEEP;
	sequence s_load(logic [20:0] v);
		pc_load_out && pc_value_out == v;
	endsequence
	a_por_pulse_hold: assert property (por_pulse_in |=> core_reset_out)
		else $error("core left reset during power-on pulse");
	a_pin_low_hold: assert property (!master_clear_pin_n_in |-> core_reset_out)
		else $error("core runs with master clear low");
	a_por_flag_values: assert property ($rose(arst_n_in) |->
		status_flags_out[6:0] == 7'h70 && pc_value_out == RESET_VECTOR)
		else $error("wrong power-on flags or program counter");
	a_wdt_run_reset: assert property (solo && watchdog_timeout_in && !nap
		|=> s_load(RESET_VECTOR) ##0 !status_flags_out[5] && core_reset_out)
		else $error("watchdog reset in run mode wrong");
	a_wdt_wake_pc: assert property (solo && watchdog_timeout_in && nap
		|=> s_load($past(pc_in) + PC_STEP) ##0 status_flags_out[5:4] == 2'h0)
		else $error("watchdog wake-up wrong");
	a_wake_stall: assert property (solo && watchdog_timeout_in && nap &&
		osc_cfg_in <= HIGH_SPEED_CRYSTAL_PLL_CFG |=> clock_wait_out [*8])
		else $error("wake-up skipped the start-up count");
	a_int_vector: assert property (solo && !watchdog_timeout_in &&
		interrupt_wake_in && nap &&
		(global_int_enable_high_in || global_int_enable_low_in) |=>
		s_load($past(int_high_priority_in) ? HIGH_INT_VECTOR : LOW_INT_VECTOR)
		##0 !status_flags_out[4])
		else $error("interrupt wake-up vector wrong");
	a_stack_soft_err: assert property (live && stack_underflow_in &&
		!stack_reset_enable_cfg_in && !reset_instr_in && !stack_full_in &&
		!watchdog_timeout_in && !interrupt_wake_in |=>
		status_flags_out[0] && !core_reset_out)
		else $error("stack underflow without reset handled wrong");
	a_rc_no_delay: assert property ($fell(por_pulse_in) && !brown_out_in &&
		master_clear_pin_n_in && powerup_timer_disable_cfg_in &&
		osc_cfg_in >= EXT_CLOCK_CFG |-> ##2 !core_reset_out)
		else $error("delay added where none is due");
endmodule
bind reset_timeout_sequencer rts_asserts i_chk (.*);
`default_nettype wire

// >>> testbench/tb_reset_timeout_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_reset_timeout_sequencer;
	import rst_seq_pkg::*;
	logic clock_in, arst_n_in, por_pulse_in, brown_out_in, hold_low;
	logic master_clear_pin_n_in, osc_input_pin_in, internal_rc_clock_in;
	logic powerup_timer_disable_cfg_in, stack_reset_enable_cfg_in;
	logic reset_instr_in, watchdog_timeout_in, stack_full_in;
	logic stack_underflow_in, interrupt_wake_in, int_high_priority_in;
	logic global_int_enable_high_in, global_int_enable_low_in, flag_write_in;
	logic core_reset_out, clock_wait_out, pc_load_out;
	logic [1:0] brownout_enable_cfg_in;
	logic [20:0] pc_in, pc_value_out;
	osc_cfg_t osc_cfg_in;
	pm_mode_t pm_mode_in;
	flags_t flag_data_in, status_flags_out;
	int err_count, checks_done, n;

	reset_timeout_sequencer #(.PLL_LOCK_CYCLES(20)) i_dut (.*);
	osc_master_clear_pin_model i_far (.clock_in(clock_in), .hold_low_in(hold_low),
		.osc_out(osc_input_pin_in), .rc_out(internal_rc_clock_in),
		.master_clear_pin_n_out(master_clear_pin_n_in));

	initial begin
		clock_in = 1'h0;
		forever #25 clock_in = ~clock_in;
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (e !== g) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic wait_run(input int lim);
		n = 0;
		while ((core_reset_out !== 1'h0 || clock_wait_out !== 1'h0) &&
			n < lim) begin
			@(negedge clock_in);
			n++;
		end
	endtask

	// Cycle counts assume one oscillator and one RC rising edge every
	// second clock, as the far-side model makes them.
	task automatic power_up(input osc_cfg_t c, input logic pd, input int hold,
		input int lo, input int hi);
		@(negedge clock_in);
		arst_n_in = 1'h0;
		por_pulse_in = 1'h1;
		osc_cfg_in = c;
		powerup_timer_disable_cfg_in = pd;
		hold_low = hold > 0;
		repeat (8) @(negedge clock_in);
		arst_n_in = 1'h1;
		repeat (4) @(negedge clock_in);
		por_pulse_in = 1'h0;
		if (hold > 0) begin
			repeat (hold) @(negedge clock_in);
			chk("pin held", 32'h1, core_reset_out);
			hold_low = 1'h0;
		end
		wait_run(20000);
		chk("cycles above", 32'h1, n >= lo);
		chk("cycles below", 32'h1, n <= hi);
		chk("por flags", {brownout_enable_cfg_in == 2'h1, 7'h70},
			status_flags_out);
	endtask

	task automatic ev(input int k, input pm_mode_t m, input logic [20:0] pc,
		input logic ld, input logic [20:0] epc, input flags_t ef);
		@(negedge clock_in);
		pm_mode_in = m;
		pc_in = pc;
		flag_data_in = ef;
		case (k)
			0: reset_instr_in = 1'h1;
			1: watchdog_timeout_in = 1'h1;
			2: stack_full_in = 1'h1;
			3: stack_underflow_in = 1'h1;
			4: interrupt_wake_in = 1'h1;
			5: hold_low = 1'h1;
			default: flag_write_in = 1'h1;
		endcase
		@(negedge clock_in);
		{reset_instr_in, watchdog_timeout_in, stack_full_in} = 3'h0;
		{stack_underflow_in, interrupt_wake_in, flag_write_in} = 3'h0;
		n = 0;
		while (ld && pc_load_out !== 1'h1 && n < 4) begin
			@(negedge clock_in);
			n++;
		end
		if (ld) begin
			chk("pc load", 32'h1, pc_load_out);
			chk("pc value", epc, pc_value_out);
		end
		chk("flags", ef, status_flags_out);
		hold_low = 1'h0;
		wait_run(5000);
	endtask

	initial begin
		repeat (40000) @(posedge clock_in);
		err_count++;
		tally_and_finish();
	end

	initial begin
		err_count = 0;
		checks_done = 0;
		arst_n_in = 1'h0;
		{por_pulse_in, brown_out_in, hold_low, flag_write_in} = 4'h8;
		{reset_instr_in, watchdog_timeout_in, stack_full_in} = 3'h0;
		{stack_underflow_in, interrupt_wake_in, int_high_priority_in} = 3'h0;
		{global_int_enable_high_in, global_int_enable_low_in} = 2'h0;
		{powerup_timer_disable_cfg_in, stack_reset_enable_cfg_in} = 2'h0;
		brownout_enable_cfg_in = 2'h0;
		osc_cfg_in = HIGH_SPEED_CRYSTAL_CFG;
		pm_mode_in = PM_FULL;
		pc_in = 21'h0;
		flag_data_in = 8'h0;
		power_up(HIGH_SPEED_CRYSTAL_CFG, 1'h0, 0, 6140, 6160);
		power_up(EXT_CLOCK_CFG, 1'h0, 0, 4092, 4112);
		power_up(HIGH_SPEED_CRYSTAL_PLL_CFG, 1'h1, 0, 2064, 2084);
		power_up(EXT_RC_CFG, 1'h1, 0, 2, 3);
		brownout_enable_cfg_in = 2'h1;
		power_up(STD_CRYSTAL_CFG, 1'h1, 3000, 1, 2);
		ev(6, PM_FULL, 21'h100, 1'h0, 21'h0, 8'hff);
		ev(1, PM_FULL, 21'h100, 1'h1, RESET_VECTOR, 8'hdf);
		ev(5, PM_RUN, 21'h100, 1'h1, RESET_VECTOR, 8'hff);
		ev(0, PM_FULL, 21'h100, 1'h1, RESET_VECTOR, 8'hbf);
		ev(5, PM_FULL, 21'h100, 1'h1, RESET_VECTOR, 8'hbf);
		ev(5, PM_IDLE, 21'h100, 1'h1, RESET_VECTOR, 8'haf);
		ev(6, PM_FULL, 21'h100, 1'h0, 21'h0, 8'hf0);
		ev(3, PM_FULL, 21'h100, 1'h0, 21'h0, 8'hf1);
		stack_reset_enable_cfg_in = 1'h1;
		ev(2, PM_FULL, 21'h100, 1'h1, RESET_VECTOR, 8'hf3);
		ev(1, PM_SLEEP, 21'h123, 1'h1, 21'h125, 8'hc3);
		for (int i = 0; i < 3; i++) begin
			{global_int_enable_high_in, global_int_enable_low_in} = 2'h2 >> i;
			int_high_priority_in = i == 0;
			ev(6, PM_FULL, 21'h200, 1'h0, 21'h0, 8'hf0);
			ev(4, i == 1 ? PM_SLEEP : PM_IDLE, 21'h200, 1'h1, i == 0 ?
				HIGH_INT_VECTOR : i == 1 ? LOW_INT_VECTOR : 21'h202, 8'he0);
		end
		@(negedge clock_in);
		brown_out_in = 1'h1;
		repeat (3) @(negedge clock_in);
		chk("brown-out flags", 8'hf0, status_flags_out);
		chk("brown-out hold", 32'h1, core_reset_out);
		brown_out_in = 1'h0;
		wait_run(5000);
		chk("restart", 32'h0, core_reset_out);
		tally_and_finish();
	end
endmodule
`default_nettype wire
